// ===== logic/bws_defs.svh
`ifndef BWS_DEFS_SVH
`define BWS_DEFS_SVH
`define BWS_DIGITS 4
`define BWS_WORD_W 16
`define BWS_MAX_DIGIT 4'h9
`define BWS_ZERO_WORD 16'h0000
`define BWS_RST_RESULT 16'h0000
`define BWS_RST_FLAG 1'b0
`endif

// ===== logic/bws_pkg.sv
package bws_pkg;
	typedef logic [15:0] bws_word_t;
	typedef enum logic {
		BWS_MODE_LEVEL,
		BWS_MODE_EDGE
	} bws_mode_t;
endpackage

// ===== logic/bws_bcd_core.sv
`timescale 1ns/100ps
`include "bws_defs.svh"
module bws_bcd_core
	import bws_pkg::*;
(
	input wire bws_word_t minuendWord,
	input wire bws_word_t subtrahendWord,
	input wire logic carryIn,
	output bws_word_t diffWord,
	output logic borrowOut,
	output logic operandBad
);
	function automatic logic digit_bad(input logic [3:0] d);
		digit_bad = d > `BWS_MAX_DIGIT;
	endfunction

	logic [4:0] raw [`BWS_DIGITS];
	logic [`BWS_DIGITS:0] borrow;

	always_comb begin
		borrow[0] = carryIn;
		operandBad = 1'b0;
		diffWord = `BWS_ZERO_WORD;
		for (int i = 0; i < `BWS_DIGITS; i++) begin
			operandBad = operandBad | digit_bad(minuendWord[i*4 +: 4]) | digit_bad(subtrahendWord[i*4 +: 4]);
			raw[i] = {1'b0, minuendWord[i*4 +: 4]} - {1'b0, subtrahendWord[i*4 +: 4]} - {4'h0, borrow[i]};
			// a digit underflow borrows ten from the next digit
			borrow[i+1] = raw[i][4];
			diffWord[i*4 +: 4] = raw[i][4] ? 4'(raw[i][3:0] + 4'hA) : raw[i][3:0];
		end
		// dropping the fifth digit leaves ten's complement when negative
		borrowOut = borrow[`BWS_DIGITS];
	end
endmodule

// ===== logic/bcd_word_subtractor.sv
// Overview of operation
// - condition false: result, error and zero flags unchanged
// - condition true: minuend minus subtrahend minus carry
// - computes 10000 plus difference, fifth digit dropped
// - negative result: carry set, ten's complement
// - carry set when minuend below subtrahend plus carry
// - zero flag tracks written result being zero
// - non-BCD operand nibble raises error flag
// - unresolved indirect operand raises error flag
// - operands and result are four-digit words
// - carry is one flag, set and clear operations
`timescale 1ns/100ps
`include "bws_defs.svh"
module bcd_word_subtractor
	import bws_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic scanStrobe,
	input wire logic execCondition,
	input wire bws_mode_t execMode,
	input wire bws_word_t minuend_word,
	input wire bws_word_t subtrahend_word,
	input wire logic indirectFault,
	input wire logic clear_carry_op,
	input wire logic set_carry_op,
	output bws_word_t resultWord_q,
	output logic carry_flag_q,
	output logic error_flag_q,
	output logic zero_flag_q,
	output logic execDone_q
);
	logic rstSync1_q;
	logic rstSyncN_q;

	logic condPrev_q;
	logic runNow;
	logic faultNow;
	logic commitNow;

	logic badOperand;
	logic borrowOut;
	bws_word_t diffWord;

	// next-state values, one per register except the two reset synchronizer stages
	logic condPrev_d;
	bws_word_t resultWord_d;
	logic carry_flag_d;
	logic zero_flag_d;
	logic error_flag_d;
	logic execDone_d;

	// differentiated mode needs a fresh rising condition
	function automatic logic exec_wanted(
		input logic strobe,
		input logic cond,
		input bws_mode_t mode,
		input logic prevCond
	);
		logic edgeOk;
		edgeOk = (mode == BWS_MODE_LEVEL) || !prevCond;
		exec_wanted = strobe && cond && edgeOk;
	endfunction

	// digit or pointer fault, either one
	function automatic logic any_fault(
		input logic digitFault,
		input logic pointerFault
	);
		any_fault = digitFault || pointerFault;
	endfunction

	function automatic logic word_is_zero(
		input bws_word_t w
	);
		word_is_zero = (w == `BWS_ZERO_WORD);
	endfunction

	// release is synchronous so no flag leaves reset on a partial edge
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rstSync1_q <= 1'b0;
			rstSyncN_q <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstSyncN_q <= rstSync1_q;
		end
	end

	// four-digit word datapath
	// operands are read live at the strobe edge; the sequencer holds them there
	bws_bcd_core core (
		.minuendWord(minuend_word),
		.subtrahendWord(subtrahend_word),
		.carryIn(carry_flag_q),
		.diffWord(diffWord),
		.borrowOut(borrowOut),
		.operandBad(badOperand)
	);

	// history only advances per scan, so a one-scan low is seen
	always_comb begin
		condPrev_d = condPrev_q;
		if (scanStrobe) begin
			condPrev_d = execCondition;
		end
	end

	always_ff @(posedge clock or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			condPrev_q <= `BWS_RST_FLAG;
		end else begin
			condPrev_q <= condPrev_d;
		end
	end

	// nothing runs unless this scan asks for it
	always_comb begin
		runNow = exec_wanted(scanStrobe, execCondition, execMode, condPrev_q);
	end

	always_comb begin
		faultNow = any_fault(badOperand, indirectFault);
	end

	// a faulted run counts as a run but writes no result, carry or zero
	always_comb begin
		commitNow = runNow && !faultNow;
	end

	// outputs all come straight from the registers below
	// difference taken only on a clean run
	always_comb begin
		resultWord_d = resultWord_q;
		if (commitNow) begin
			resultWord_d = diffWord;
		end
	end

	always_ff @(posedge clock or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			resultWord_q <= `BWS_RST_RESULT;
		end else begin
			resultWord_q <= resultWord_d;
		end
	end

	// a run owns the carry, ops only act in cycles with no run
	// holding carry through a faulted run keeps its borrow meaning
	// set wins over clear when both arrive together
	always_comb begin
		carry_flag_d = carry_flag_q;
		if (commitNow) begin
			carry_flag_d = borrowOut;
		end else if (runNow) begin
			carry_flag_d = carry_flag_q;
		end else if (set_carry_op) begin
			carry_flag_d = 1'b1;
		end else if (clear_carry_op) begin
			carry_flag_d = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			carry_flag_q <= `BWS_RST_FLAG;
		end else begin
			carry_flag_q <= carry_flag_d;
		end
	end

	// zero follows the word being written
	always_comb begin
		zero_flag_d = zero_flag_q;
		if (commitNow) begin
			zero_flag_d = word_is_zero(diffWord);
		end
	end

	always_ff @(posedge clock or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			zero_flag_q <= `BWS_RST_FLAG;
		end else begin
			zero_flag_q <= zero_flag_d;
		end
	end

	// error rewritten on every run, clean or not
	always_comb begin
		error_flag_d = error_flag_q;
		if (runNow) begin
			error_flag_d = faultNow;
		end
	end

	always_ff @(posedge clock or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			error_flag_q <= `BWS_RST_FLAG;
		end else begin
			error_flag_q <= error_flag_d;
		end
	end

	// pulse marks any execution attempt, faulted ones included
	always_comb begin
		execDone_d = runNow;
	end

	always_ff @(posedge clock or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			execDone_q <= `BWS_RST_FLAG;
		end else begin
			execDone_q <= execDone_d;
		end
	end
endmodule

// ===== tb/bws_chk.sv
`timescale 1ns/100ps
module bws_chk
	import bws_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic scanStrobe,
	input wire logic execCondition,
	input wire bws_mode_t execMode,
	input wire logic indirectFault,
	input wire logic set_carry_op,
	input wire logic clear_carry_op,
	input wire bws_word_t resultWord_q,
	input wire logic carry_flag_q,
	input wire logic error_flag_q,
	input wire logic zero_flag_q,
	input wire logic execDone_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_on;
		scanStrobe && execCondition;
	endsequence
	sequence s_level_run;
		s_on ##0 execMode == BWS_MODE_LEVEL;
	endsequence
	sequence s_gap_rerun;
		s_on ##1 !scanStrobe ##1 s_on ##0 execMode == BWS_MODE_EDGE;
	endsequence
	property p_idle;
		scanStrobe && !execCondition |=> $stable({resultWord_q, error_flag_q, zero_flag_q});
	endproperty
	a_idle: assert property (p_idle) else $error("idle change");
	property p_keep;
		execDone_q && error_flag_q |-> $stable({resultWord_q, carry_flag_q, zero_flag_q});
	endproperty
	a_keep: assert property (p_keep) else $error("error wrote");
	property p_once;
		s_gap_rerun |=> !execDone_q;
	endproperty
	a_once: assert property (p_once) else $error("edge rerun");
	property p_run;
		s_level_run |=> execDone_q;
	endproperty
	a_run: assert property (p_run) else $error("level run missed");
	property p_fault;
		s_level_run ##0 indirectFault |=> error_flag_q;
	endproperty
	a_fault: assert property (p_fault) else $error("fault not flagged");
	property p_zero;
		execDone_q && !error_flag_q |-> zero_flag_q == (resultWord_q == 16'h0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_digits;
		execDone_q && !error_flag_q |-> resultWord_q[3:0] <= 4'h9 && resultWord_q[7:4] <= 4'h9
			&& resultWord_q[11:8] <= 4'h9 && resultWord_q[15:12] <= 4'h9;
	endproperty
	a_digits: assert property (p_digits) else $error("result not bcd");
	property p_carry_hold;
		!scanStrobe && !set_carry_op && !clear_carry_op |=> $stable(carry_flag_q);
	endproperty
	a_carry_hold: assert property (p_carry_hold) else $error("carry moved");
endmodule
bind bcd_word_subtractor bws_chk chk (
	.clock(clock),
	.arst_n(arst_n),
	.scanStrobe(scanStrobe),
	.execCondition(execCondition),
	.execMode(execMode),
	.indirectFault(indirectFault),
	.set_carry_op(set_carry_op),
	.clear_carry_op(clear_carry_op),
	.resultWord_q(resultWord_q),
	.carry_flag_q(carry_flag_q),
	.error_flag_q(error_flag_q),
	.zero_flag_q(zero_flag_q),
	.execDone_q(execDone_q)
);

// ===== tb/bws_seq_model.sv
`timescale 1ns/100ps
module bws_seq_model
	import bws_pkg::*;
(
	input wire logic clock,
	output logic scanStrobe,
	output logic execCondition,
	output logic indirectFault,
	output logic set_carry_op,
	output logic clear_carry_op,
	output bws_word_t minuend_word,
	output bws_word_t subtrahend_word
);
	initial {scanStrobe, execCondition, indirectFault, set_carry_op, clear_carry_op, minuend_word, subtrahend_word} = '0;
	task automatic issue(input logic [3:0] k, input bws_word_t m, input bws_word_t s);
		{set_carry_op, clear_carry_op} = k[1:0];
		@(negedge clock);
		{set_carry_op, clear_carry_op, scanStrobe, execCondition, indirectFault} = {2'h0, 1'h1, k[3:2]};
		{minuend_word, subtrahend_word} = {m, s};
		@(negedge clock);
		scanStrobe = 1'h0;
		// operands go stale once taken
		{minuend_word, subtrahend_word} = ~{m, s};
	endtask
endmodule

// ===== tb/bcd_word_subtractor_bench.sv
`timescale 1ns/100ps
module bcd_word_subtractor_bench
	import bws_pkg::*;
;
	logic clock = 1'h0;
	logic arst_n = 1'h0;
	bws_mode_t execMode = BWS_MODE_LEVEL;
	logic scanStrobe;
	logic execCondition;
	logic indirectFault;
	logic set_carry_op;
	logic clear_carry_op;
	logic carry_flag_q;
	logic error_flag_q;
	logic zero_flag_q;
	logic execDone_q;
	bws_word_t minuend_word;
	bws_word_t subtrahend_word;
	bws_word_t resultWord_q;
	logic [19:0] seen;
	int miscompares = 0;
	int total_checks = 0;
	bws_seq_model seq (
		.clock(clock),
		.scanStrobe(scanStrobe),
		.execCondition(execCondition),
		.indirectFault(indirectFault),
		.set_carry_op(set_carry_op),
		.clear_carry_op(clear_carry_op),
		.minuend_word(minuend_word),
		.subtrahend_word(subtrahend_word)
	);
	bcd_word_subtractor dut (
		.clock(clock),
		.arst_n(arst_n),
		.scanStrobe(scanStrobe),
		.execCondition(execCondition),
		.execMode(execMode),
		.minuend_word(minuend_word),
		.subtrahend_word(subtrahend_word),
		.indirectFault(indirectFault),
		.clear_carry_op(clear_carry_op),
		.set_carry_op(set_carry_op),
		.resultWord_q(resultWord_q),
		.carry_flag_q(carry_flag_q),
		.error_flag_q(error_flag_q),
		.zero_flag_q(zero_flag_q),
		.execDone_q(execDone_q)
	);
	initial begin
		forever #25 clock = ~clock;
	end
	task automatic final_report;
		$display("%0d checks, %0d mismatches", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input logic [19:0] got, input logic [19:0] want);
		total_checks++;
		if (got !== want) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h, want %h", $time, got, want);
		end
	endtask
	// k packs condition, fault, set, clear; flags pack carry, error, zero, done
	task automatic step(input logic [3:0] k, input bws_word_t m, input bws_word_t s, output logic [19:0] got);
		seq.issue(k, m, s);
		got = {resultWord_q, carry_flag_q, error_flag_q, zero_flag_q, execDone_q};
		$display("step ended at %0t", $time);
	endtask
	initial begin
		repeat (12) @(negedge clock);
		arst_n = 1'h1;
		repeat (3) @(negedge clock);
		step(4'h9, 16'h1029, 16'h3452, seen);
		check(seen, 20'h75779);
		step(4'h9, 16'h0000, 16'h7577, seen);
		check(seen, 20'h24239);
		step(4'h8, 16'h5000, 16'h1000, seen);
		check(seen, 20'h39991);
		step(4'hA, 16'h0000, 16'h0000, seen);
		check(seen, 20'h99999);
		step(4'h8, 16'h3A00, 16'h0001, seen);
		check(seen, 20'h9999D);
		step(4'hC, 16'h1111, 16'h0001, seen);
		check(seen, 20'h9999D);
		step(4'h0, 16'h1111, 16'h0001, seen);
		check(seen, 20'h9999C);
		execMode = BWS_MODE_EDGE;
		step(4'h9, 16'h0003, 16'h0003, seen);
		check(seen, 20'h00003);
		step(4'h8, 16'h0009, 16'h0001, seen);
		check(seen, 20'h00002);
		final_report;
	end
endmodule
